// file: ism_regs.svh
// constants shared by both ends of the two-wire serial memory link
// assumes a 200 MHz system clock on both ends and plain APB on the host
`ifndef ISM_REGS_SVH
`define ISM_REGS_SVH

// memory array
`define ISM_MEM_WORDS      8192
`define ISM_MEM_AW         13
`define ISM_ADDR_HI_W      5
`define ISM_ADDR_HI_LSB    8

// address word layout; type code value is arbitrary
`define ISM_TYPE_CODE      4'h6
`define ISM_TYPE_MSB       7
`define ISM_TYPE_LSB       4
`define ISM_SEL_MSB        3
`define ISM_SEL_LSB        1
`define ISM_RW_BIT         0

// bit slot counter values
`define ISM_BITS_PER_BYTE  4'h8
`define ISM_ACK_SLOT       4'h9

// timing
`define ISM_CLK_PERIOD_NS  5
`define ISM_SCL_PERIOD_NS  2500
`define ISM_QUARTER_CYC    ((`ISM_SCL_PERIOD_NS / 4) / `ISM_CLK_PERIOD_NS)
`define ISM_QDIV_W         8

// host APB register map
`define ISM_APB_AW         8
`define ISM_REG_CTRL       8'h00
`define ISM_REG_TXDATA     8'h04
`define ISM_REG_RXDATA     8'h08
`define ISM_REG_STATUS     8'h0C
`define ISM_CTRL_CMD_MSB   1
`define ISM_CTRL_CMD_LSB   0
`define ISM_CTRL_ACK_BIT   2
`define ISM_STAT_BUSY_BIT  0
`define ISM_STAT_NACK_BIT  1

`endif

// file: ism_pkg.sv
// types shared by both ends of the two-wire serial memory link
// assumes ism_regs.svh supplies the numeric constants
`default_nettype none

package ism_pkg;

   typedef enum logic [2:0]
   {
      ISM_DST_IDLE,
      ISM_DST_DEVADDR,
      ISM_DST_ADDR_HI,
      ISM_DST_ADDR_LO,
      ISM_DST_WRITE,
      ISM_DST_READ
   } ism_dev_state_t;

   typedef enum logic [1:0]
   {
      ISM_HST_IDLE,
      ISM_HST_START,
      ISM_HST_STOP,
      ISM_HST_BYTE
   } ism_host_state_t;

   typedef enum logic [1:0]
   {
      ISM_CMD_START,
      ISM_CMD_STOP,
      ISM_CMD_WRITE,
      ISM_CMD_READ
   } ism_cmd_t;

endpackage : ism_pkg

`default_nettype wire

// file: ism_link_if.sv
// two-wire link between the bus master end and the memory end
// the data wire is open drain with a pull-up, resolved here from the enables
`timescale 1ns/100ps
`default_nettype none

interface ism_link_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic sda;

   // released wire floats high through the pull-up
   assign sda = (host_sda_oe ? host_sda_o : 1'b1) &
                (dev_sda_oe  ? dev_sda_o  : 1'b1);

   modport host
   (
      output scl,
      output host_sda_o,
      output host_sda_oe,
      input  sda
   );

   modport device
   (
      input  scl,
      input  sda,
      output dev_sda_o,
      output dev_sda_oe
   );
endinterface : ism_link_if

`default_nettype wire

// file: ism_sync.sv
// two-flop synchroniser with edge pulses, one lane per bit
// assumes inputs come from outside the clk domain
`timescale 1ns/100ps
`default_nettype none

module ism_sync #(parameter int W = 1)
(
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // asynchronous inputs
   input  wire logic [W-1:0] async_in,
   // synchronised level and edges
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] stable_reg;
   logic [W-1:0] prev_reg;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_lane
         // meta_reg feeds only stable_reg
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               meta_reg[i]   <= 1'b1;
               stable_reg[i] <= 1'b1;
               prev_reg[i]   <= 1'b1;
            end
            else
            begin
               meta_reg[i]   <= async_in[i];
               stable_reg[i] <= meta_reg[i];
               prev_reg[i]   <= stable_reg[i];
            end
         end
         assign level[i] = stable_reg[i];
         assign rise[i]  = stable_reg[i] & ~prev_reg[i];
         assign fall[i]  = ~stable_reg[i] & prev_reg[i];
      end
   endgenerate
endmodule : ism_sync

`default_nettype wire

// file: ism_device.sv
// memory end of the two-wire link: slave decoder plus 8K x 8 array
// assumes the far end supplies every clock pulse and start/stop
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ism_regs.svh"

module ism_device
(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // two-wire link
   ism_link_if.device              link,
   // strap pins, tie low when unused
   input  wire logic               addr_select_bit0,
   input  wire logic               addr_select_bit1,
   input  wire logic               addr_select_bit2,
   input  wire logic               write_protect,
   // status
   output var ism_pkg::ism_dev_state_t link_state
);
   import ism_pkg::*;

   ism_dev_state_t      state_reg;
   logic [3:0]          cnt_reg;
   logic [7:0]          rx_reg;
   logic [7:0]          tx_reg;
   logic                rw_reg;
   logic                mack_reg;
   logic                oe_reg;
   logic                sda_o_reg;
   logic [`ISM_MEM_AW-1:0] addr_reg;
   logic [7:0]          mem [0:`ISM_MEM_WORDS-1];

   logic [1:0]          link_lvl;
   logic [1:0]          link_rise;
   logic [1:0]          link_fall;
   logic [3:0]          strap_lvl;
   logic                scl_lvl;
   logic                sda_lvl;
   logic                start_det;
   logic                stop_det;
   logic                busy;
   logic                bit_rise;
   logic                ack_rise;
   logic                byte_end;
   logic                ack_end;
   logic                mid_fall;
   logic                addr_match;
   logic                load_next;
   logic [2:0]          sel_code;
   logic                wp_lvl;

   // both link wires share one pipeline so their edges stay aligned
   ism_sync #(.W(2)) u_link_sync
   (
      .clk      (clk),
      .rst      (rst),
      .async_in ({link.scl, link.sda}),
      .level    (link_lvl),
      .rise     (link_rise),
      .fall     (link_fall)
   );

   ism_sync #(.W(4)) u_strap_sync
   (
      .clk      (clk),
      .rst      (rst),
      .async_in ({write_protect, addr_select_bit2,
                  addr_select_bit1, addr_select_bit0}),
      .level    (strap_lvl),
      .rise     (),
      .fall     ()
   );

   assign scl_lvl  = link_lvl[1];
   assign sda_lvl  = link_lvl[0];
   // a released strap is pulled low outside, so low is the idle meaning
   assign sel_code = strap_lvl[2:0];
   assign wp_lvl   = strap_lvl[3];

   // conditions are data edges while the clock stays high
   assign start_det = scl_lvl & link_fall[0];
   assign stop_det  = scl_lvl & link_rise[0];

   assign busy     = (state_reg != ISM_DST_IDLE);
   assign bit_rise = busy & link_rise[1] &
                     (cnt_reg < `ISM_BITS_PER_BYTE);
   assign ack_rise = busy & link_rise[1] &
                     (cnt_reg == `ISM_BITS_PER_BYTE);
   assign byte_end = busy & link_fall[1] &
                     (cnt_reg == `ISM_BITS_PER_BYTE);
   assign ack_end  = busy & link_fall[1] &
                     (cnt_reg == `ISM_ACK_SLOT);
   assign mid_fall = busy & link_fall[1] & (state_reg == ISM_DST_READ) &
                     (cnt_reg != 4'h0) &
                     (cnt_reg < `ISM_BITS_PER_BYTE);

   assign addr_match =
      (rx_reg[`ISM_TYPE_MSB:`ISM_TYPE_LSB] == `ISM_TYPE_CODE) &&
      (rx_reg[`ISM_SEL_MSB:`ISM_SEL_LSB] == sel_code);

   // next read byte after the address word or a master ack
   assign load_next = ack_end &
      (((state_reg == ISM_DST_DEVADDR) & rw_reg) |
       ((state_reg == ISM_DST_READ) & mack_reg));

   // transfer sequencing
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= ISM_DST_IDLE;
         cnt_reg   <= 4'h0;
      end
      else if (start_det)
      begin
         state_reg <= ISM_DST_DEVADDR;
         cnt_reg   <= 4'h0;
      end
      else if (stop_det)
      begin
         // no write wait: standby follows the stop directly
         state_reg <= ISM_DST_IDLE;
         cnt_reg   <= 4'h0;
      end
      else if (bit_rise)
      begin
         cnt_reg <= cnt_reg + 4'h1;
      end
      else if (ack_rise)
      begin
         cnt_reg <= `ISM_ACK_SLOT;
      end
      else if (byte_end && state_reg == ISM_DST_DEVADDR && !addr_match)
      begin
         state_reg <= ISM_DST_IDLE;
         cnt_reg   <= 4'h0;
      end
      else if (ack_end)
      begin
         cnt_reg <= 4'h0;
         case (state_reg)
            ISM_DST_DEVADDR:
               state_reg <= rw_reg ? ISM_DST_READ : ISM_DST_ADDR_HI;
            ISM_DST_ADDR_HI:
               state_reg <= ISM_DST_ADDR_LO;
            ISM_DST_ADDR_LO:
               state_reg <= ISM_DST_WRITE;
            ISM_DST_WRITE:
               state_reg <= ISM_DST_WRITE;
            ISM_DST_READ:
               // master did not ack: park released until next start
               state_reg <= mack_reg ? ISM_DST_READ : ISM_DST_IDLE;
            default:
               state_reg <= ISM_DST_IDLE;
         endcase
      end
   end

   // receive shifter and direction bit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rx_reg <= 8'h00;
         rw_reg <= 1'b0;
      end
      else
      begin
         if (bit_rise)
         begin
            rx_reg <= {rx_reg[6:0], sda_lvl};
         end
         if (byte_end && state_reg == ISM_DST_DEVADDR)
         begin
            rw_reg <= rx_reg[`ISM_RW_BIT];
         end
      end
   end

   // master acknowledge of a read byte, low means continue
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         mack_reg <= 1'b0;
      end
      else if (ack_rise && state_reg == ISM_DST_READ)
      begin
         mack_reg <= ~sda_lvl;
      end
   end

   // memory address pointer, survives between transfers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         addr_reg <= {`ISM_MEM_AW{1'b0}};
      end
      else if (byte_end && state_reg == ISM_DST_ADDR_HI)
      begin
         // upper bits of the high byte carry no address
         addr_reg[`ISM_MEM_AW-1:`ISM_ADDR_HI_LSB] <=
            rx_reg[`ISM_ADDR_HI_W-1:0];
      end
      else if (byte_end && state_reg == ISM_DST_ADDR_LO)
      begin
         addr_reg[`ISM_ADDR_HI_LSB-1:0] <= rx_reg;
      end
      else if ((byte_end && state_reg == ISM_DST_WRITE) || load_next)
      begin
         // natural 13-bit overflow wraps the top location to zero
         addr_reg <= addr_reg + `ISM_MEM_AW'(1);
      end
   end

   // array write lands at the byte end, no deferred programming
   always_ff @(posedge clk)
   begin
      if (byte_end && state_reg == ISM_DST_WRITE && !wp_lvl)
      begin
         mem[addr_reg] <= rx_reg;
      end
   end

   // open-drain driver: ack and read bits change on clock falls only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         oe_reg <= 1'b0;
         tx_reg <= 8'h00;
      end
      else if (start_det || stop_det)
      begin
         oe_reg <= 1'b0;
      end
      else if (byte_end)
      begin
         if (state_reg == ISM_DST_READ)
         begin
            oe_reg <= 1'b0;
         end
         else
         begin
            // a refused address word is simply left unacknowledged
            oe_reg <= (state_reg != ISM_DST_DEVADDR) || addr_match;
         end
      end
      else if (load_next)
      begin
         // read path ignores write protect
         tx_reg <= mem[addr_reg];
         oe_reg <= ~mem[addr_reg][7];
      end
      else if (ack_end)
      begin
         oe_reg <= 1'b0;
      end
      else if (mid_fall)
      begin
         tx_reg <= {tx_reg[6:0], 1'b0};
         oe_reg <= ~tx_reg[6];
      end
   end

   // output level is always low; only the enable moves
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sda_o_reg <= 1'b0;
      end
      else
      begin
         sda_o_reg <= 1'b0;
      end
   end

   assign link.dev_sda_oe = oe_reg;
   assign link.dev_sda_o  = sda_o_reg;
   assign link_state      = state_reg;
endmodule : ism_device

`default_nettype wire

// file: ism_host.sv
// bus master end of the two-wire link, run by commands over APB
// assumes a single master, no clock stretching by the far end
`timescale 1ns/100ps
`default_nettype none
`include "ism_regs.svh"

module ism_host
(
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // APB slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`ISM_APB_AW-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // two-wire link
   ism_link_if.host                    link,
   // engine state
   output var ism_pkg::ism_host_state_t host_state
);
   import ism_pkg::*;

   ism_host_state_t          state_reg;
   logic [`ISM_QDIV_W-1:0]   qdiv_reg;
   logic [1:0]               quarter_reg;
   logic [3:0]               bit_reg;
   logic [7:0]               tx_reg;
   logic [7:0]               txdata_reg;
   logic [7:0]               rx_reg;
   logic                     is_read_reg;
   logic                     ack_en_reg;
   logic                     nack_reg;
   logic                     scl_reg;
   logic                     oe_reg;
   logic                     sda_o_reg;
   logic [31:0]              prdata_reg;
   logic                     pready_reg;
   logic                     pslverr_reg;

   logic                     sda_lvl;
   logic                     tick;
   logic                     apb_wr;
   logic                     cmd_go;
   logic                     mapped;
   logic                     last_bit;
   ism_cmd_t                 cmd;

   ism_sync #(.W(1)) u_sda_sync
   (
      .clk      (clk),
      .rst      (rst),
      .async_in (link.sda),
      .level    (sda_lvl),
      .rise     (),
      .fall     ()
   );

   assign tick     = (qdiv_reg == `ISM_QDIV_W'(`ISM_QUARTER_CYC - 1));
   assign apb_wr   = psel & penable & pready_reg & pwrite;
   assign cmd      = ism_cmd_t'(pwdata[`ISM_CTRL_CMD_MSB:`ISM_CTRL_CMD_LSB]);
   // commands written while busy are dropped
   assign cmd_go   = apb_wr & (paddr == `ISM_REG_CTRL) &
                     (state_reg == ISM_HST_IDLE);
   assign last_bit = (bit_reg == `ISM_BITS_PER_BYTE);
   assign mapped   = (paddr == `ISM_REG_CTRL) | (paddr == `ISM_REG_TXDATA) |
                     (paddr == `ISM_REG_RXDATA) | (paddr == `ISM_REG_STATUS);

   // APB: no wait states, pready high in the first access cycle, answer registered in the setup cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end
      else
      begin
         pready_reg  <= psel & ~penable;
         pslverr_reg <= psel & ~penable & ~mapped;
         if (psel && !penable)
         begin
            case (paddr)
               `ISM_REG_TXDATA: prdata_reg <= {24'h00_0000, txdata_reg};
               `ISM_REG_RXDATA: prdata_reg <= {24'h00_0000, rx_reg};
               `ISM_REG_STATUS: prdata_reg <= {30'h0000_0000, nack_reg,
                                   state_reg != ISM_HST_IDLE};
               default:         prdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         txdata_reg <= 8'h00;
      end
      else if (apb_wr && paddr == `ISM_REG_TXDATA)
      begin
         txdata_reg <= pwdata[7:0];
      end
   end

   // quarter-period timebase, parked while idle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         qdiv_reg    <= '0;
         quarter_reg <= 2'h0;
      end
      else if (state_reg == ISM_HST_IDLE)
      begin
         qdiv_reg    <= '0;
         quarter_reg <= 2'h0;
      end
      else if (tick)
      begin
         qdiv_reg    <= '0;
         quarter_reg <= quarter_reg + 2'h1;
      end
      else
      begin
         qdiv_reg <= qdiv_reg + `ISM_QDIV_W'(1);
      end
   end

   // engine: byte data moves in quarter 0 while the clock is low; start and stop also move it in quarter 2 while the clock is high
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg   <= ISM_HST_IDLE;
         scl_reg     <= 1'b1;
         oe_reg      <= 1'b0;
         bit_reg     <= 4'h0;
         tx_reg      <= 8'h00;
         rx_reg      <= 8'h00;
         is_read_reg <= 1'b0;
         ack_en_reg  <= 1'b0;
         nack_reg    <= 1'b0;
      end
      else if (cmd_go)
      begin
         bit_reg     <= 4'h0;
         tx_reg      <= txdata_reg;
         is_read_reg <= (cmd == ISM_CMD_READ);
         ack_en_reg  <= pwdata[`ISM_CTRL_ACK_BIT];
         case (cmd)
            ISM_CMD_START: state_reg <= ISM_HST_START;
            ISM_CMD_STOP:  state_reg <= ISM_HST_STOP;
            default:       state_reg <= ISM_HST_BYTE;
         endcase
      end
      else if (tick)
      begin
         case (state_reg)
            ISM_HST_START:
               case (quarter_reg)
                  2'h0: oe_reg  <= 1'b0;
                  2'h1: scl_reg <= 1'b1;
                  2'h2: oe_reg  <= 1'b1;
                  default:
                  begin
                     scl_reg   <= 1'b0;
                     state_reg <= ISM_HST_IDLE;
                  end
               endcase
            ISM_HST_STOP:
               case (quarter_reg)
                  2'h0: oe_reg  <= 1'b1;
                  2'h1: scl_reg <= 1'b1;
                  2'h2: oe_reg  <= 1'b0;
                  default: state_reg <= ISM_HST_IDLE;
               endcase
            ISM_HST_BYTE:
               case (quarter_reg)
                  2'h0:
                     if (last_bit)
                        oe_reg <= is_read_reg & ack_en_reg;
                     else
                        oe_reg <= ~is_read_reg & ~tx_reg[7];
                  2'h1: scl_reg <= 1'b1;
                  2'h2:
                     if (!last_bit)
                        rx_reg <= {rx_reg[6:0], sda_lvl};
                     else if (!is_read_reg)
                        nack_reg <= sda_lvl;
                  default:
                  begin
                     scl_reg <= 1'b0;
                     tx_reg  <= {tx_reg[6:0], 1'b0};
                     bit_reg <= bit_reg + 4'h1;
                     if (last_bit)
                        state_reg <= ISM_HST_IDLE;
                  end
               endcase
            default:
               state_reg <= ISM_HST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sda_o_reg <= 1'b0;
      else
         sda_o_reg <= 1'b0;
   end

   assign link.scl         = scl_reg;
   assign link.host_sda_oe = oe_reg;
   assign link.host_sda_o  = sda_o_reg;
   assign prdata           = prdata_reg;
   assign pready           = pready_reg;
   assign pslverr          = pslverr_reg;
   assign host_state       = state_reg;
endmodule : ism_host

`default_nettype wire

// file: ism_link_properties.sv
// link assertions for the two ends of the serial memory link
// assumes one clk domain; inputs are the ism_link_if wires
`timescale 1ns/100ps
`default_nettype none

module ism_link_props
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // link wires
   input  wire logic scl,
   input  wire logic host_sda_o,
   input  wire logic host_sda_oe,
   input  wire logic dev_sda_o,
   input  wire logic dev_sda_oe,
   input  wire logic sda
);
   logic       scl_q;
   logic [7:0] since_fall;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // saturating so a long idle stretch never wraps into a false window
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         scl_q      <= 1'b1;
         since_fall <= 8'hFF;
      end
      else
      begin
         scl_q      <= scl;
         since_fall <= (scl_q && !scl) ? 8'h00 :
                       (since_fall == 8'hFF) ? 8'hFF : since_fall + 8'h01;
      end
   end

   a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
      else $error("memory end drives data high");
   a_host_open_drain: assert property (host_sda_oe |-> !host_sda_o)
      else $error("master end drives data high");
   a_dev_quiet_high: assert property
      (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("memory end moved data while clock high");
   a_dev_after_fall: assert property
      ($changed(dev_sda_oe) |-> since_fall <= 8'h08)
      else $error("memory end moved data away from a clock fall");
   a_start_by_host: assert property
      (scl && $fell(sda) |-> host_sda_oe)
      else $error("start not made by master end");
   a_stop_by_host: assert property
      (scl && $past(scl) && $rose(sda) |-> $past(host_sda_oe))
      else $error("memory end released data while clock high");
   a_stop_standby: assert property
      (scl && $rose(sda) |=> !dev_sda_oe [*8])
      else $error("memory end drives after stop");
   a_clk_high_hold: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
endmodule : ism_link_props

`default_nettype wire

// file: tb_top.sv
// bench: APB commands to the master end, memory end on the same link
// assumes straps select code 3'h5
`timescale 1ns/100ps
`default_nettype none
`include "ism_regs.svh"

module tb_top;
   import ism_pkg::*;

   logic           clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]     paddr;
   logic [31:0]    pwdata, prdata, rd;
   logic           err, write_protect;
   logic [2:0]     sel;
   ism_dev_state_t link_state;
   ism_host_state_t host_state;
   int             num_errors, checks, cycles;
   localparam logic [7:0] DEV_W = {`ISM_TYPE_CODE, 3'h5, 1'b0};
   localparam logic [7:0] DEV_X = {`ISM_TYPE_CODE, 3'h4, 1'b0};
   // straps match but the type code does not
   localparam logic [7:0] DEV_T = {~`ISM_TYPE_CODE, 3'h5, 1'b0};

   ism_link_if ism_link_if_i();
   ism_host ism_host_i(.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link(ism_link_if_i), .host_state(host_state));
   ism_device ism_device_i(.clk(clk), .rst(rst), .link(ism_link_if_i),
      .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
      .addr_select_bit2(sel[2]), .write_protect(write_protect),
      .link_state(link_state));
   ism_link_props ism_link_props_i(.clk(clk), .rst(rst),
      .scl(ism_link_if_i.scl), .host_sda_o(ism_link_if_i.host_sda_o),
      .host_sda_oe(ism_link_if_i.host_sda_oe), .sda(ism_link_if_i.sda),
      .dev_sda_o(ism_link_if_i.dev_sda_o),
      .dev_sda_oe(ism_link_if_i.dev_sda_oe));

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // request stands until pready is sampled high; answer taken at that edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cmd(input ism_cmd_t c, input logic [7:0] tx,
                      input logic ack);
      apb(1'b1, `ISM_REG_TXDATA, {24'h0, tx});
      apb(1'b1, `ISM_REG_CTRL, {29'h0, ack, c});
      // a stuck engine is ended by the cycle ceiling, not here
      do
      begin
         apb(1'b0, `ISM_REG_STATUS, 32'h0);
      end
      while (rd[`ISM_STAT_BUSY_BIT] !== 1'b0);
   endtask : cmd

   task automatic wb(input logic [7:0] tx, input logic nack);
      cmd(ISM_CMD_WRITE, tx, 1'b0);
      chk({31'h0, rd[`ISM_STAT_NACK_BIT]}, {31'h0, nack});
   endtask : wb

   task automatic rb(input logic ack, input logic [7:0] exp);
      cmd(ISM_CMD_READ, 8'h00, ack);
      apb(1'b0, `ISM_REG_RXDATA, 32'h0);
      chk(rd, {24'h0, exp});
   endtask : rb

   task automatic addr_1fff;
      cmd(ISM_CMD_START, 8'h00, 1'b0);
      wb(DEV_W, 1'b0);
      wb(8'h1F, 1'b0);
      wb(8'hFF, 1'b0);
   endtask : addr_1fff

   task automatic stop_idle;
      cmd(ISM_CMD_STOP, 8'h00, 1'b0);
      chk({29'h0, link_state}, {29'h0, ISM_DST_IDLE});
      chk({30'h0, host_state}, {30'h0, ISM_HST_IDLE});
   endtask : stop_idle

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // a hang is cut short at 95000 cycles, a little past the expected run length of about 82000
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 95000)
      begin
         num_errors++;
         final_report();
      end
   end

   initial
   begin
      {rst, psel, penable, pwrite, paddr, pwdata} <= {1'b1, 43'h0};
      {sel, write_protect} <= {3'h5, 1'b0};
      {num_errors, checks, cycles} = 96'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      addr_1fff();
      wb(8'hA5, 1'b0);
      wb(8'h3C, 1'b0);
      stop_idle();
      $display("test page_write done");
      write_protect <= 1'b1;
      addr_1fff();
      wb(8'h77, 1'b0);
      stop_idle();
      $display("test protected_write done");
      addr_1fff();
      cmd(ISM_CMD_START, 8'h00, 1'b0);
      wb(DEV_W | 8'h01, 1'b0);
      rb(1'b1, 8'hA5);
      rb(1'b0, 8'h3C);
      stop_idle();
      $display("test read_wrap done");
      write_protect <= 1'b0;
      cmd(ISM_CMD_START, 8'h00, 1'b0);
      wb(DEV_X, 1'b1);
      chk({29'h0, link_state}, {29'h0, ISM_DST_IDLE});
      cmd(ISM_CMD_START, 8'h00, 1'b0);
      wb(DEV_T, 1'b1);
      chk({29'h0, link_state}, {29'h0, ISM_DST_IDLE});
      stop_idle();
      $display("test wrong_select done");
      final_report();
   end
endmodule : tb_top

`default_nettype wire
